// ==== rbo_pkg.sv ====
// constants and types shared by the block output design
package rbo_pkg;
	localparam int          BLK_BITS   = 26;
	localparam int          SYN_BITS   = 10;
	localparam int          FIFO_DEPTH = 16;
	localparam int          OUT_HALF   = 4;
	localparam logic [9:0]  SYN_POLY   = 10'h1B9;
	localparam logic [1:0]  BLK_SECOND = 2'h1;
	localparam logic [4:0]  BIT_LAST   = 5'h19;
	typedef enum logic [2:0] {
		ST_IDLE  = 3'h1,
		ST_START = 3'h2,
		ST_SHIFT = 3'h4
	} rbo_state_t;
endpackage

// ==== rbo_fifo.sv ====
// synchronous word fifo with valid and ready on both sides
`timescale 1ns/1ps
module rbo_fifo #(
	parameter int WIDTH = 27,
	parameter int DEPTH = 16
) (
	// clock and reset
	input  wire logic             clk_sys,
	input  wire logic             rst,
	// fill side
	input  wire logic             inValid,
	output logic                  inReady,
	input  wire logic [WIDTH-1:0] inData,
	// drain side
	output logic                  outValid,
	input  wire logic             outReady,
	output logic      [WIDTH-1:0] outData
);
	localparam int AW = $clog2(DEPTH);

	initial begin
		if (DEPTH < 2 || (1 << AW) != DEPTH || WIDTH < 1)
			$error("rbo_fifo: depth must be a power of two of at least 2");
	end

	logic [WIDTH-1:0] mem [DEPTH];
	logic [AW-1:0]    wrPtr_reg;
	logic [AW-1:0]    rdPtr_reg;
	logic [AW:0]      count_reg;
	logic             doPush;
	logic             doPop;

	// depth is a power of two, so the top count bit alone marks full
	assign inReady  = !count_reg[AW];
	assign outValid = (count_reg != '0);
	assign outData  = mem[rdPtr_reg];
	assign doPush   = inValid && inReady;
	assign doPop    = outValid && outReady;

	always_ff @(posedge clk_sys) begin
		if (doPush)
			mem[wrPtr_reg] <= inData;
	end

	always_ff @(posedge clk_sys) begin
		if (rst) begin
			wrPtr_reg <= '0;
			rdPtr_reg <= '0;
			count_reg <= '0;
		end else begin
			if (doPush)
				wrPtr_reg <= wrPtr_reg + 1'b1;
			if (doPop)
				rdPtr_reg <= rdPtr_reg + 1'b1;
			if (doPush && !doPop)
				count_reg <= count_reg + 1'b1;
			else if (doPop && !doPush)
				count_reg <= count_reg - 1'b1;
		end
	end
endmodule // rbo_fifo

// ==== rbo_block_output.sv ====
// broadcast data block capture, delay and serial output
//
// Function
// RULE1: the demodulator data bit is captured on each falling edge of its bit clock.
// RULE2: the demodulator keeps data stable around the falling edge, changing it on the rising one.
// RULE3: each block is sent on the serial output one block period after it arrived; the code queues it in the fifo and sends it once the serializer is idle.
// RULE4: error and correction lines stay asserted without a gap over consecutive bad blocks.
// RULE5: reception in progress is shown only while block data is being shifted out.
// RULE6: the host controller should be able to drive the reset of the device.
// RULE7: start select low pulses block start for every block, high only for the second block.
// RULE8: the reset input is held active for at least four oscillator clock cycles.
// RULE9: correction is driven low for bad blocks, error low only for uncorrectable ones.
`timescale 1ns/1ps
module rbo_block_output #(
	parameter int                 HALF_CYC = rbo_pkg::OUT_HALF,
	parameter logic [9:0]         POLY     = rbo_pkg::SYN_POLY
) (
	// system clock and reset
	input  wire logic clk_sys,
	input  wire logic rst,
	// demodulator link
	input  wire logic linkClk,
	input  wire logic serDataIn,
	// option pins
	input  wire logic corrSel,
	input  wire logic clkEdgeSel,
	input  wire logic startSel,
	// serial output
	output logic      serDataOut,
	output logic      serClkOut,
	output logic      dataStartN,
	// open-drain status, enable high pulls low
	output logic      receiveOe,
	output logic      correctOe,
	output logic      errorOe
);
	import rbo_pkg::*;

	initial begin
		if (HALF_CYC < 1 || HALF_CYC > 255)
			$error("rbo_block_output: HALF_CYC out of range");
	end

	function automatic logic [SYN_BITS-1:0] rboSyndrome(input logic [BLK_BITS-1:0] w);
		logic [SYN_BITS-1:0] rem;
		logic                msb;
		rem = '0;
		msb = 1'b0;
		for (int i = BLK_BITS - 1; i >= 0; i--) begin
			msb = rem[SYN_BITS-1];
			rem = {rem[SYN_BITS-2:0], w[i]};
			if (msb)
				rem = rem ^ POLY;
		end
		return rem;
	endfunction

	// link domain, runs only while the demodulator clocks
	logic                lrstMeta_reg;
	logic                lrst_reg;
	logic [BLK_BITS-2:0] shiftIn_reg;
	logic [4:0]          bitCnt_reg;
	logic [BLK_BITS-1:0] hold_reg;
	logic                linkTog_reg;

	always_ff @(negedge linkClk) begin
		lrstMeta_reg <= rst;
		lrst_reg     <= lrstMeta_reg;
	end

	// RULE1: falling-edge capture
	always_ff @(negedge linkClk) begin
		if (lrst_reg) begin
			shiftIn_reg <= '0;
			bitCnt_reg  <= '0;
			hold_reg    <= '0;
			linkTog_reg <= 1'b0;
		end else begin
			shiftIn_reg <= {shiftIn_reg[BLK_BITS-3:0], serDataIn};
			if (bitCnt_reg == BIT_LAST) begin
				bitCnt_reg  <= '0;
				hold_reg    <= {shiftIn_reg, serDataIn};
				linkTog_reg <= ~linkTog_reg;
			end else begin
				bitCnt_reg <= bitCnt_reg + 1'b1;
			end
		end
	end

	// RULE1: one toggle per 26 captured bits
	AST_CAPTURE_BLOCK: assert property (@(negedge linkClk) disable iff (lrst_reg) // RULE1
		bitCnt_reg == BIT_LAST |=> linkTog_reg != $past(linkTog_reg))
		else $error("block toggle missing after last bit");

	// system domain: pins and toggle through two flops
	logic [3:0] pinMeta_reg;
	logic [3:0] pinSync_reg;
	logic       togSync;
	logic       corrSync;
	logic       edgeSync;
	logic       startSync;
	logic       togSeen_reg;

	always_ff @(posedge clk_sys) begin
		if (rst) begin
			pinMeta_reg <= '0;
			pinSync_reg <= '0;
		end else begin
			pinMeta_reg <= {linkTog_reg, corrSel, clkEdgeSel, startSel};
			pinSync_reg <= pinMeta_reg;
		end
	end
	assign togSync   = pinSync_reg[3];
	assign corrSync  = pinSync_reg[2];
	assign edgeSync  = pinSync_reg[1];
	assign startSync = pinSync_reg[0];

	// hold_reg is stable for 26 link bits after the toggle, so reading it here is safe
	logic                fifoInValid;
	logic                fifoInReady;
	logic                fifoOutValid;
	logic                fifoOutReady;
	logic [BLK_BITS:0]   fifoIn;
	logic [BLK_BITS:0]   fifoOut;

	assign fifoInValid = togSync ^ togSeen_reg;
	assign fifoIn      = {rboSyndrome(hold_reg) != '0, hold_reg};

	// a full fifo holds the toggle unseen, while the link-side capture keeps running
	always_ff @(posedge clk_sys) begin
		if (rst)
			togSeen_reg <= 1'b0;
		else if (fifoInValid && fifoInReady)
			togSeen_reg <= togSync;
	end

	rbo_fifo #(
		.WIDTH (BLK_BITS + 1),
		.DEPTH (FIFO_DEPTH)
	) u_fifo (
		.clk_sys  (clk_sys),
		.rst      (rst),
		.inValid  (fifoInValid),
		.inReady  (fifoInReady),
		.inData   (fifoIn),
		.outValid (fifoOutValid),
		.outReady (fifoOutReady),
		.outData  (fifoOut)
	);

	// serializer
	rbo_state_t          state_reg;
	logic [7:0]          halfCnt_reg;
	logic                phase_reg;
	logic [4:0]          outCnt_reg;
	logic [BLK_BITS-1:0] shiftOut_reg;
	logic [1:0]          blkIdx_reg;
	logic                halfDone;
	logic                pop;

	assign halfDone     = (halfCnt_reg == 8'(HALF_CYC - 1));
	assign fifoOutReady = (state_reg == ST_IDLE);
	assign pop          = fifoOutValid && fifoOutReady;

	// RULE3: block leaves after it fully arrived
	always_ff @(posedge clk_sys) begin
		if (rst) begin
			state_reg    <= ST_IDLE;
			halfCnt_reg  <= '0;
			phase_reg    <= 1'b0;
			outCnt_reg   <= '0;
			shiftOut_reg <= '0;
			blkIdx_reg   <= '0;
		end else begin
			halfCnt_reg <= (state_reg == ST_IDLE || halfDone) ? 8'h00 : halfCnt_reg + 1'b1;
			if (halfDone)
				phase_reg <= ~phase_reg;
			case (state_reg)
				ST_IDLE: begin
					phase_reg <= 1'b0;
					if (pop) begin
						shiftOut_reg <= fifoOut[BLK_BITS-1:0];
						state_reg    <= ST_START;
					end
				end
				ST_START: begin
					if (halfDone && phase_reg) begin
						outCnt_reg <= '0;
						state_reg  <= ST_SHIFT;
					end
				end
				ST_SHIFT: begin
					if (halfDone && phase_reg) begin
						shiftOut_reg <= {shiftOut_reg[BLK_BITS-2:0], 1'b0};
						outCnt_reg   <= outCnt_reg + 1'b1;
						if (outCnt_reg == BIT_LAST) begin
							blkIdx_reg <= blkIdx_reg + 1'b1;
							state_reg  <= ST_IDLE;
						end
					end
				end
				default: state_reg <= ST_IDLE;
			endcase
		end
	end

	// output pins, all registered
	always_ff @(posedge clk_sys) begin
		if (rst) begin
			serDataOut <= 1'b1;
			serClkOut  <= 1'b1;
		end else if (state_reg == ST_SHIFT) begin
			serDataOut <= shiftOut_reg[BLK_BITS-1];
			serClkOut  <= phase_reg ^ edgeSync;
		end else begin
			serDataOut <= 1'b1;
			serClkOut  <= 1'b1;
		end
	end

	// RULE7: start pulse for all or only the second block
	always_ff @(posedge clk_sys) begin
		if (rst)
			dataStartN <= 1'b1;
		else
			dataStartN <= !(state_reg == ST_START && (!startSync || blkIdx_reg == BLK_SECOND));
	end

	// RULE5: low only while bits go out
	always_ff @(posedge clk_sys) begin
		if (rst)
			receiveOe <= 1'b0;
		else
			receiveOe <= (state_reg == ST_SHIFT);
	end

	// RULE4 RULE9: flags change only when a new block is taken
	always_ff @(posedge clk_sys) begin
		if (rst) begin
			correctOe <= 1'b0;
			errorOe   <= 1'b0;
		end else if (pop) begin
			// no corrector yet, so any bad block is uncorrectable in both corrSel modes
			correctOe <= fifoOut[BLK_BITS] || (corrSync && 1'b0);
			errorOe   <= fifoOut[BLK_BITS];
		end
	end

	// RULE9: error never without correction
	AST_ERR_WITH_CORR: assert property (@(posedge clk_sys) disable iff (rst) // RULE9
		errorOe |-> correctOe)
		else $error("error line low without correction line");

	// RULE4: flags only move on a block load
	AST_FLAGS_HOLD: assert property (@(posedge clk_sys) disable iff (rst) // RULE4
		!$stable(errorOe) || !$stable(correctOe) |-> $past(pop))
		else $error("status flags changed between blocks");

	// RULE5: receive only during shifting
	AST_RX_WINDOW: assert property (@(posedge clk_sys) disable iff (rst) // RULE5
		receiveOe |-> $past(state_reg == ST_SHIFT) && $past(outCnt_reg) <= BIT_LAST)
		else $error("receive asserted outside data shifting");

	// RULE7: pulse gated by select
	AST_START_SEL: assert property (@(posedge clk_sys) disable iff (rst) // RULE7
		$fell(dataStartN) |-> $past(!startSync || blkIdx_reg == BLK_SECOND))
		else $error("start pulse on a block it was not selected for");

	// RULE3: a waiting block enters the start state the cycle after idle
	AST_BLOCK_LAUNCH: assert property (@(posedge clk_sys) disable iff (rst) // RULE3
		state_reg == ST_IDLE && fifoOutValid |-> ##1 state_reg == ST_START ##1 receiveOe == 1'b0)
		else $error("queued block not launched");
endmodule // rbo_block_output

// ==== rbo_demod_model.sv ====
// demodulator model driving bit clock and data
`timescale 1ns/1ps
module rbo_demod_model (
	// demodulator link
	output logic linkClk,
	output logic serDataIn
);
	// link clock stands still high outside frames
	initial begin
		linkClk   = 1'b1;
		serDataIn = 1'b0;
	end

	// sends bits n-1 down to 0 of w, first bit first
	task automatic send_bits(input logic [25:0] w, input int n);
		for (int i = n - 1; i >= 0; i--) begin
			serDataIn = w[i];
			#24 linkClk = 1'b0;
			#24 linkClk = 1'b1;
		end
		// released line must not look valid
		serDataIn = ~serDataIn;
	endtask
endmodule // rbo_demod_model

// ==== test_rbo_block_output.sv ====
// self-checking bench of the block output path
`timescale 1ns/1ps
module test_rbo_block_output;
	import rbo_pkg::*;
	logic        clk_sys = 1'b0;
	logic        rst = 1'b1;
	logic        corrSel = 1'b0;
	logic        clkEdgeSel = 1'b0;
	logic        startSel = 1'b0;
	logic        linkClk, serDataIn, serDataOut, serClkOut, dataStartN;
	logic        receiveOe, correctOe, errorOe;
	logic        prevSclk, prevRecv, prevStart, sawStart, lastBad;
	logic [25:0] shiftWord;
	logic [26:0] expQ[$];
	int          bitCnt, outIdx, inCount, n_errors, cmp_count;
	int          seed = 32'h1A856CCB;

	always #20 clk_sys = ~clk_sys;

	// short half period so the fifo drains fast and does not overflow
	rbo_block_output #(.HALF_CYC(1)) dut (
		.clk_sys(clk_sys), .rst(rst), .linkClk(linkClk), .serDataIn(serDataIn),
		.corrSel(corrSel), .clkEdgeSel(clkEdgeSel), .startSel(startSel),
		.serDataOut(serDataOut), .serClkOut(serClkOut), .dataStartN(dataStartN),
		.receiveOe(receiveOe), .correctOe(correctOe), .errorOe(errorOe));
	rbo_demod_model dem (.linkClk(linkClk), .serDataIn(serDataIn));

	// data plus check bits, zero syndrome
	function automatic logic [25:0] make_block(input logic [15:0] d);
		logic [9:0] r;
		r = 10'h000;
		for (int i = 15; i >= 0; i--)
			r = {r[8:0], 1'b0} ^ ((d[i] ^ r[9]) ? SYN_POLY : 10'h000);
		return {d, r};
	endfunction

	task automatic check(input logic ok, input string msg);
		cmp_count++;
		if (ok !== 1'b1) begin
			n_errors++;
			$display("FAIL %0t %s", $time, msg);
		end
	endtask

	task automatic print_verdict();
		$display("errors %0d comparisons %0d", n_errors, cmp_count);
		if (n_errors == 0 && cmp_count > 0) begin
			$display("NO MISMATCHES");
		end else begin
			$display("MISMATCHES SEEN");
		end
		$finish;
	endtask

	// output monitor, sampled on the system clock
	always @(posedge clk_sys) begin
		prevSclk  <= serClkOut;
		prevRecv  <= receiveOe;
		prevStart <= dataStartN;
		if (rst) begin
			sawStart <= 1'b0;
			lastBad  <= 1'b0;
			bitCnt   <= 0;
			outIdx   <= 0;
		end else begin
			// before the pop, so the pair is old and current block
			// at a block end the next block may already be loaded
			if (prevRecv === 1'b1 && receiveOe === 1'b0) begin
				if (expQ.size() > 1 && expQ[0][26] && expQ[1][26])
					check(correctOe === 1'b1 && errorOe === 1'b1, "flag gap at end");
			end else if (lastBad && expQ.size() > 0 && expQ[0][26]) begin
				check(correctOe === 1'b1 && errorOe === 1'b1, "flag gap");
			end
			if (prevStart === 1'b1 && dataStartN === 1'b0) sawStart <= 1'b1;
			if (serClkOut !== prevSclk && serClkOut === ~clkEdgeSel) begin
				check(receiveOe === 1'b1, "clock edge outside reception");
				if (expQ.size() > 0)
					check(correctOe === expQ[0][26] && errorOe === expQ[0][26], "flags");
				shiftWord <= {shiftWord[24:0], serDataOut};
				bitCnt    <= bitCnt + 1;
			end
			if (prevRecv === 1'b0 && receiveOe === 1'b1) begin
				check(sawStart === (startSel === 1'b0 || outIdx % 4 == 1), "start");
				check(inCount > outIdx, "output ahead of input");
			end
			if (prevRecv === 1'b1 && receiveOe === 1'b0) begin
				check(expQ.size() > 0 && bitCnt == 26 && shiftWord === expQ[0][25:0], "word");
				if (expQ.size() > 0) begin
					lastBad <= expQ[0][26];
					void'(expQ.pop_front());
				end
				sawStart <= 1'b0;
				bitCnt   <= 0;
				outIdx   <= outIdx + 1;
			end
		end
	end

	task automatic do_reset();
		rst <= 1'b1;
		dem.send_bits(26'h0000000, 4);
		@(posedge clk_sys);
		check(serDataOut === 1'b1 && serClkOut === 1'b1 && dataStartN === 1'b1 &&
			receiveOe === 1'b0 && correctOe === 1'b0 && errorOe === 1'b0, "reset");
		rst <= 1'b0;
		expQ.delete();
		inCount = 0;
		// two falls clear the link reset, the third already captures
		dem.send_bits(26'h0000000, 2);
	endtask

	// back-to-back blocks, first three bad
	task automatic send_run(input int n);
		logic [25:0] w;
		logic        bad;
		for (int i = 0; i < n; i++) begin
			bad = (i < 3) || ($random(seed) % 3 == 0);
			w = make_block(16'($random(seed)));
			if (bad) w = w ^ (26'h0000001 << ($unsigned($random(seed)) % 26));
			expQ.push_back({bad, w});
			dem.send_bits(w, 26);
			inCount++;
		end
	endtask

	task automatic drain();
		int t;
		t = 0;
		while ((expQ.size() != 0 || receiveOe !== 1'b0) && t < 20000) begin
			@(posedge clk_sys);
			t++;
		end
		check(t < 20000, "drain timeout");
		if (t >= 20000) print_verdict();
	endtask

	initial begin
		repeat (2) @(posedge clk_sys);
		do_reset();
		for (int p = 0; p < 5; p++) begin
			@(posedge clk_sys);
			clkEdgeSel <= p[0];
			startSel   <= p[1];
			corrSel    <= 1'($random(seed));
			repeat (3) @(posedge clk_sys);
			// last run long enough to back up the fifo
			send_run(p == 4 ? 18 : 6);
			drain();
			if (p == 2) do_reset();
		end
		print_verdict();
	end
endmodule // test_rbo_block_output
